// ==== rtl/pib_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`default_nettype none
module pib_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // handshakes and honest full/empty
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pib_io_buffer.sv ====
// peripheral i/o buffer: host byte bus, 16 peripheral lines, timer, daisy-chained irq
// Operation
// [RULE1] host data lines float except while driving read data or a vector
// [RULE2] bus control decode is sampled only at the host strobe edge
// [RULE3] the same host strobe advances the sixteen-bit timer
// [RULE4] register reads and writes happen only while chip enable is low
// [RULE5] interrupt request is an open-drain low, wire-or capable
// [RULE6] mask in/out daisy chain; no request while upstream is serviced
// [RULE7] top-priority device has its mask input tied to ground
// [RULE8] end-of-service pulse ends the interrupt currently in service
// [RULE9] peripheral lines are weak highs the peripheral may pull low
// [RULE10] peripheral go output is high when activity is requested
// [RULE11] falling attention request sets the ready flag
// [RULE12] ready set with peripheral irq enable raises an interrupt
// [RULE13] error input shows in control bit 1, interrupts when enabled
// [RULE14] data register access clears ready, restarting the peripheral
// [RULE15] bits 7 and 6 give even parity of low and high byte
// [RULE16] bit 5 gates the timer clock and timer interrupts
// [RULE17] bit 4 enables timer interrupt requests
// [RULE18] bit 3 enables attention and error interrupt requests
// [RULE19] bit 2 selects 8 or 16 bit handshake width
// [RULE20] control register readable and writable; bit 0 is ready
// [RULE21] two data registers and three vector registers, eight bits each
// [RULE22] active-low power clear initialises the registers
// [RULE23] eight consecutive register addresses from base N
// [RULE24] after acknowledge the matching vector is driven in vector fetch
// [RULE25] error ranks highest, timer lowest
// [RULE26] power clear values for data, timer, vectors, ready and enables
// [RULE27] in 16-bit width ready clears only on high byte access
// [RULE28] parity bits follow the current peripheral line levels
`default_nettype none
module pib_io_buffer
  import pib_pkg::*;
#(
  parameter int FIFO_D = pib_pkg::FIFO_DEPTH
) (
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        HOST_STROBE_CLOCK_I,
  input  wire logic        BUS_DIRECTION_I,
  input  wire logic        BUS_CTL_A_I,
  input  wire logic        BUS_CTL_B_I,
  input  wire logic        CHIP_ENABLE_N_I,
  input  wire logic [7:0]  HOST_DATA_LINES_I,
  output logic [7:0]       HOST_DATA_LINES_O,
  output logic             HOST_DATA_LINES_OE_N_O,
  input  wire logic        END_OF_SERVICE_PULSE_I,
  output logic             IRQ_OUT_N_O,
  output logic             IRQ_OUT_N_OE_N_O,
  input  wire logic        PRIORITY_MASK_IN_I,
  output logic             PRIORITY_MASK_OUT_O,
  input  wire logic        POWER_CLEAR_N_I,
  input  wire logic [15:0] PERIPH_LINES_I,
  output logic [15:0]      PERIPH_LINES_O,
  output logic [15:0]      PERIPH_LINES_OE_N_O,
  output logic             PERIPH_GO_O,
  input  wire logic        ATTENTION_REQ_N_I,
  input  wire logic        PERIPH_ERROR_N_I
);
  import pib_pkg::*;

  // ********************************
  // pin synchronisers
  // ********************************
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] flt_q;

  assign pin_raw = {HOST_STROBE_CLOCK_I, BUS_DIRECTION_I, BUS_CTL_B_I, BUS_CTL_A_I,
                    CHIP_ENABLE_N_I, END_OF_SERVICE_PULSE_I, ATTENTION_REQ_N_I,
                    PERIPH_ERROR_N_I, PRIORITY_MASK_IN_I, POWER_CLEAR_N_I,
                    HOST_DATA_LINES_I, PERIPH_LINES_I};

  // three stages; a bit is taken once stages two and three agree
  always_ff @(posedge REF_CLK_I) begin
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // filtered levels, idle values after reset
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      flt_q <= {10'h02d, 8'h00, 16'hffff};     // strobe low, enables and clear high
    end else begin
      flt_q <= (flt_q & ~(s2_q ~^ s3_q)) | (s3_q & (s2_q ~^ s3_q));
    end
  end

  logic        strobe_lvl;
  logic [2:0]  phase;
  logic        ce_n;
  logic        eos_lvl;
  logic        att_n;
  logic        err_n;
  logic        mask_in;
  logic        power_clear_n_n;
  logic [7:0]  hd_in;
  logic [15:0] pd_in;
  assign strobe_lvl = flt_q[33];
  assign phase      = flt_q[32:30];
  assign ce_n       = flt_q[29];
  assign eos_lvl    = flt_q[28];
  assign att_n      = flt_q[27];
  assign err_n      = flt_q[26];
  assign mask_in    = flt_q[25];   // tied low on the top device of the chain [RULE7]
  assign power_clear_n_n     = flt_q[24];
  assign hd_in      = flt_q[23:16];
  assign pd_in      = flt_q[15:0];

  // ********************************
  // edge detection on filtered levels
  // ********************************
  logic strobe_d1_q;
  logic att_d1_q;
  logic err_d1_q;
  logic eos_d1_q;
  logic strobe_ev;
  logic att_fall;
  logic err_fall;
  logic eos_ev;
  logic clr;

  // previous levels
  always_ff @(posedge REF_CLK_I) begin
    if (!NRST_I) begin
      strobe_d1_q <= 1'b0;
      att_d1_q    <= 1'b1;
      err_d1_q    <= 1'b1;
      eos_d1_q    <= 1'b0;
    end else begin
      strobe_d1_q <= strobe_lvl;
      att_d1_q    <= att_n;
      err_d1_q    <= err_n;
      eos_d1_q    <= eos_lvl;
    end
  end

  assign strobe_ev = strobe_lvl & ~strobe_d1_q;  // decode taken only here [RULE2]
  assign att_fall  = att_d1_q & ~att_n;
  assign err_fall  = err_d1_q & ~err_n;
  assign eos_ev    = eos_lvl & ~eos_d1_q;
  assign clr       = ~NRST_I | ~power_clear_n_n;          // power clear initialises [RULE22]

  // ********************************
  // bus address phase and write path
  // ********************************
  logic       sel_q;
  logic [2:0] idx_q;
  logic       wr_valid;
  logic       wr_ready;
  logic       dr_valid;
  logic       dr_ready;
  logic [10:0] dr_data;
  logic       rd_cyc;
  logic       wr_cyc;
  logic       data_hit;
  logic       hi_hit;

  // chip enable and register index latched in the address phase
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      sel_q <= 1'b0;
      idx_q <= IDX_CTRL;
    end else if (strobe_ev && phase == PH_BAR) begin
      sel_q <= ~ce_n;                            // only selected when enable low [RULE4]
      idx_q <= hd_in[2:0];                       // eight consecutive indices [RULE23]
    end
  end

  assign rd_cyc   = strobe_ev & sel_q & (phase == PH_DTB);
  assign wr_cyc   = strobe_ev & sel_q & (phase == PH_DWS || phase == PH_DW);
  assign wr_valid = wr_cyc & wr_ready;           // write dropped if the fifo is full
  assign data_hit = (idx_q == IDX_DATA_LO) | (idx_q == IDX_DATA_HI);
  assign hi_hit   = (idx_q == IDX_DATA_HI);

  pib_fifo #(
    .WIDTH (11),
    .DEPTH (FIFO_D)
  ) u_wr_fifo (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (~clr),
    .in_valid_i  (wr_valid),
    .in_ready_o  (wr_ready),
    .in_data_i   ({idx_q, hd_in}),
    .out_valid_o (dr_valid),
    .out_ready_i (dr_ready),
    .out_data_o  (dr_data)
  );

  // drain stalls while a read answer is on the bus
  assign dr_ready = HOST_DATA_LINES_OE_N_O;

  logic       apply;
  logic [2:0] a_idx;
  logic [7:0] a_dat;
  assign apply = dr_valid & dr_ready;
  assign a_idx = dr_data[10:8];
  assign a_dat = dr_data[7:0];

  // ********************************
  // register file
  // ********************************
  logic [7:0] data_lo_q;
  logic [7:0] data_hi_q;
  logic [7:0] vec_per_q;
  logic [7:0] vec_tmr_q;
  logic [7:0] vec_err_q;
  logic       tce_q;
  logic       tie_q;
  logic       pie_q;
  logic       width_q;

  // data and vector registers [RULE21]
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      data_lo_q <= RST_DATA;                     // lines idle high [RULE26]
      data_hi_q <= RST_DATA;
      vec_per_q <= RST_VEC;
      vec_tmr_q <= RST_VEC;
      vec_err_q <= RST_VEC;
    end else if (apply) begin
      case (a_idx)
        IDX_DATA_LO: data_lo_q <= a_dat;
        IDX_DATA_HI: data_hi_q <= a_dat;
        IDX_VEC_PER: vec_per_q <= a_dat;
        IDX_VEC_TMR: vec_tmr_q <= a_dat;
        IDX_VEC_ERR: vec_err_q <= a_dat;
        default: ;
      endcase
    end
  end

  // writable control bits 5..2 [RULE20]
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      {tce_q, tie_q, pie_q, width_q} <= RST_CFG; // enables and width cleared [RULE26]
    end else if (apply && a_idx == IDX_CTRL) begin
      tce_q   <= a_dat[CB_TCE];
      tie_q   <= a_dat[CB_TIE];
      pie_q   <= a_dat[CB_PIE];
      width_q <= a_dat[CB_WIDTH];
    end
  end

  // ********************************
  // ready flag and handshake
  // ********************************
  logic ready_q;
  logic ready_clr;
  // 8-bit: any data access; 16-bit: high byte only [RULE19] [RULE27]
  assign ready_clr = (rd_cyc | wr_cyc) & data_hit & (~width_q | hi_hit);

  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      ready_q <= RST_READY;
    end else if (att_fall) begin
      ready_q <= 1'b1;                           // set wins over clear [RULE11]
    end else if (ready_clr) begin
      ready_q <= 1'b0;                           // restart peripheral [RULE14]
    end
  end

  // ********************************
  // timer
  // ********************************
  logic [15:0] tmr_q;
  logic [2:0]  div_q;
  logic        eoc_q;
  logic        tmr_wr;
  logic        tick;
  logic        ack_take;
  pib_src_e    src_sel;
  assign tmr_wr = apply & (a_idx == IDX_TMR_LO || a_idx == IDX_TMR_HI);
  assign tick   = strobe_ev & tce_q & (div_q == TMR_DIV_LAST);

  // strobe divider, runs only while gated on [RULE3] [RULE16]
  always_ff @(posedge REF_CLK_I) begin
    if (clr || !tce_q) begin
      div_q <= '0;
    end else if (strobe_ev) begin
      div_q <= div_q + 3'h1;
    end
  end

  // down counter; wraps to full count after zero
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      tmr_q <= RST_TIMER;                        // full count [RULE26]
    end else if (tmr_wr) begin
      if (a_idx == IDX_TMR_LO) begin
        tmr_q[7:0] <= a_dat;
      end else begin
        tmr_q[15:8] <= a_dat;
      end
    end else if (tick) begin
      tmr_q <= tmr_q - 16'h0001;
    end
  end

  // end of count flag; loading the timer clears it
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      eoc_q <= 1'b0;
    end else if (tick && tmr_q == 16'h0001) begin
      eoc_q <= 1'b1;
    end else if (tmr_wr || (ack_take && src_sel == SRC_TMR)) begin
      eoc_q <= 1'b0;
    end
  end

  // ********************************
  // interrupt sources and daisy chain
  // ********************************
  logic     per_pend_q;
  logic     err_pend_q;
  logic     req_err;
  logic     req_per;
  logic     req_tmr;
  logic     req_any;
  logic     ack_q;
  pib_src_e svc_q;

  assign req_err = err_pend_q & pie_q;           // error gated by enable [RULE13] [RULE18]
  assign req_per = per_pend_q & pie_q;           // ready interrupt [RULE12] [RULE18]
  assign req_tmr = eoc_q & tie_q & tce_q;        // timer gated [RULE16] [RULE17]
  // no new request while upstream or this device is in service [RULE6]
  assign req_any = (req_err | req_per | req_tmr) & ~mask_in & (svc_q == SRC_NONE);
  assign ack_take = strobe_ev & (phase == PH_IRQ_ACKNOWLEDGE) & ~IRQ_OUT_N_OE_N_O;

  // error first, timer last [RULE25]
  always_comb begin
    if (req_err) begin
      src_sel = SRC_ERR;
    end else if (req_per) begin
      src_sel = SRC_PER;
    end else if (req_tmr) begin
      src_sel = SRC_TMR;
    end else begin
      src_sel = SRC_NONE;
    end
  end

  // sticky event flags; a new event beats the acknowledge clear
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      per_pend_q <= 1'b0;
      err_pend_q <= 1'b0;
    end else begin
      if (att_fall) begin
        per_pend_q <= 1'b1;
      end else if ((ack_take && src_sel == SRC_PER) || ready_clr) begin
        per_pend_q <= 1'b0;
      end
      if (err_fall) begin
        err_pend_q <= 1'b1;
      end else if (ack_take && src_sel == SRC_ERR) begin
        err_pend_q <= 1'b0;
      end
    end
  end

  // source in service until the end-of-service pulse
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      svc_q <= SRC_NONE;
      ack_q <= 1'b0;
    end else begin
      if (ack_take) begin
        svc_q <= src_sel;
        ack_q <= 1'b1;
      end else if (eos_ev) begin
        svc_q <= SRC_NONE;                       // service ends [RULE8]
      end
      if (strobe_ev && phase == PH_IAB) begin
        ack_q <= 1'b0;
      end
    end
  end

  // open-drain request and mask to downstream devices
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      IRQ_OUT_N_O         <= 1'b0;
      IRQ_OUT_N_OE_N_O    <= 1'b1;
      PRIORITY_MASK_OUT_O <= 1'b0;
    end else begin
      IRQ_OUT_N_O         <= 1'b0;               // only ever pulls low [RULE5]
      IRQ_OUT_N_OE_N_O    <= ~req_any;
      PRIORITY_MASK_OUT_O <= mask_in | req_any | (svc_q != SRC_NONE) | ack_take;
    end
  end

  // ********************************
  // host read path
  // ********************************
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;
  logic [7:0] vec_mux;
  // parity from live line levels, 1 = even [RULE15] [RULE28]
  assign ctrl_rd = {~^pd_in[7:0], ~^pd_in[15:8], tce_q, tie_q, pie_q, width_q,
                    err_n, ready_q};             // error level and ready [RULE13] [RULE20]

  always_comb begin
    case (idx_q)
      IDX_CTRL:    rd_mux = ctrl_rd;
      IDX_DATA_LO: rd_mux = pd_in[7:0];
      IDX_DATA_HI: rd_mux = pd_in[15:8];
      IDX_TMR_LO:  rd_mux = tmr_q[7:0];
      IDX_TMR_HI:  rd_mux = tmr_q[15:8];
      IDX_VEC_PER: rd_mux = vec_per_q;
      IDX_VEC_TMR: rd_mux = vec_tmr_q;
      default:     rd_mux = vec_err_q;
    endcase
  end

  always_comb begin
    case (svc_q)
      SRC_ERR: vec_mux = vec_err_q;
      SRC_PER: vec_mux = vec_per_q;
      SRC_TMR: vec_mux = vec_tmr_q;
      default: vec_mux = RST_VEC;
    endcase
  end

  // drive for one bus phase, float otherwise [RULE1]
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      HOST_DATA_LINES_O      <= '0;
      HOST_DATA_LINES_OE_N_O <= 1'b1;
    end else if (strobe_ev) begin
      if (rd_cyc) begin
        HOST_DATA_LINES_O      <= rd_mux;
        HOST_DATA_LINES_OE_N_O <= 1'b0;
      end else if (phase == PH_IAB && ack_q) begin
        HOST_DATA_LINES_O      <= vec_mux;       // vector fetch answer [RULE24]
        HOST_DATA_LINES_OE_N_O <= 1'b0;
      end else begin
        HOST_DATA_LINES_OE_N_O <= 1'b1;
      end
    end
  end

  // ********************************
  // peripheral side outputs
  // ********************************
  always_ff @(posedge REF_CLK_I) begin
    if (clr) begin
      PERIPH_LINES_O      <= '0;
      PERIPH_LINES_OE_N_O <= {RST_DATA, RST_DATA};
      PERIPH_GO_O         <= ~RST_READY;
    end else begin
      PERIPH_LINES_O      <= '0;
      PERIPH_LINES_OE_N_O <= {data_hi_q, data_lo_q}; // ones released to weak high [RULE9]
      PERIPH_GO_O         <= ~ready_q;           // go while not ready [RULE10]
    end
  end
endmodule
`default_nettype wire

// ==== rtl/pib_pkg.sv ====
// constants shared by the peripheral i/o buffer design
`default_nettype none
package pib_pkg;
  // ********************************
  // register indices (base N + index)
  // ********************************
  localparam logic [2:0] IDX_CTRL     = 3'h0;
  localparam logic [2:0] IDX_DATA_LO  = 3'h1;
  localparam logic [2:0] IDX_DATA_HI  = 3'h2;
  localparam logic [2:0] IDX_TMR_LO   = 3'h3;
  localparam logic [2:0] IDX_TMR_HI   = 3'h4;
  localparam logic [2:0] IDX_VEC_PER  = 3'h5;
  localparam logic [2:0] IDX_VEC_TMR  = 3'h6;
  localparam logic [2:0] IDX_VEC_ERR  = 3'h7;
  // ********************************
  // control register bit positions
  // ********************************
  localparam int CB_READY   = 0;
  localparam int CB_ERR     = 1;
  localparam int CB_WIDTH   = 2;
  localparam int CB_PIE     = 3;
  localparam int CB_TIE     = 4;
  localparam int CB_TCE     = 5;
  localparam int CB_PAR_HI  = 6;
  localparam int CB_PAR_LO  = 7;
  // ********************************
  // values after power clear
  // ********************************
  localparam logic [7:0]  RST_DATA   = 8'hff;
  localparam logic [15:0] RST_TIMER  = 16'hffff;
  localparam logic [7:0]  RST_VEC    = 8'h00;
  localparam logic        RST_READY  = 1'b1;
  localparam logic [3:0]  RST_CFG    = 4'h0;   // tce, tie, pie, width
  // ********************************
  // bus phase codes {dir, ctl_b, ctl_a}
  // ********************************
  localparam logic [2:0] PH_NACT  = 3'h0;
  localparam logic [2:0] PH_IAB   = 3'h2;
  localparam logic [2:0] PH_DTB   = 3'h3;
  localparam logic [2:0] PH_BAR   = 3'h4;
  localparam logic [2:0] PH_DW    = 3'h5;
  localparam logic [2:0] PH_DWS   = 3'h6;
  localparam logic [2:0] PH_IRQ_ACKNOWLEDGE = 3'h7;
  // ********************************
  // counts
  // ********************************
  localparam logic [2:0] TMR_DIV_LAST = 3'h7;  // timer steps every 8th strobe
  localparam int         FIFO_DEPTH   = 8;
  localparam int         SYNC_W       = 34;    // pin inputs gathered for sync
  // interrupt source in service
  typedef enum logic [1:0] {SRC_NONE, SRC_ERR, SRC_PER, SRC_TMR} pib_src_e;
endpackage
`default_nettype wire

// ==== verification/pib_io_buffer_bench.sv ====
// self-checking bench for the peripheral i/o buffer
`default_nettype none
module pib_io_buffer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import pib_pkg::*;
  logic        clk, nrst, stb, dir, cb, ca, ce_n, eos, mask_in, power_clear_n_n, err_n;
  logic        hd_oe_n, irq_o, irq_oe_n, mask_out, go, att_n;
  logic [7:0]  hd, hd_o, lat;
  logic [15:0] pull, lines, lines_o, lines_oe_n;
  int          n_tests = 0;
  int          n_errors = 0;
  int          cycles = 0;
  pib_io_buffer uut (.REF_CLK_I(clk), .NRST_I(nrst), .HOST_STROBE_CLOCK_I(stb),
    .BUS_DIRECTION_I(dir), .BUS_CTL_A_I(ca), .BUS_CTL_B_I(cb), .CHIP_ENABLE_N_I(ce_n),
    .HOST_DATA_LINES_I(hd), .HOST_DATA_LINES_O(hd_o), .HOST_DATA_LINES_OE_N_O(hd_oe_n),
    .END_OF_SERVICE_PULSE_I(eos), .IRQ_OUT_N_O(irq_o), .IRQ_OUT_N_OE_N_O(irq_oe_n),
    .PRIORITY_MASK_IN_I(mask_in), .PRIORITY_MASK_OUT_O(mask_out),
    .POWER_CLEAR_N_I(power_clear_n_n), .PERIPH_LINES_I(lines), .PERIPH_LINES_O(lines_o),
    .PERIPH_LINES_OE_N_O(lines_oe_n), .PERIPH_GO_O(go), .ATTENTION_REQ_N_I(att_n),
    .PERIPH_ERROR_N_I(err_n));
  pib_periph_model far (.clk_i(clk), .go_i(go), .oe_n_i(lines_oe_n), .pull_i(pull),
    .lat_i(lat), .lines_o(lines), .att_n_o(att_n));
  // ****************
  // clock, timeout and verdict
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // ****************
  // host bus cycles: phase and data held over a whole strobe period
  // ****************
  task automatic cyc(input logic [2:0] ph, input logic [7:0] d);
    {dir, cb, ca} <= ph;
    hd <= d;
    stb <= 1'b1;
    repeat (10) @(posedge clk);
    stb <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    cyc(PH_BAR, {5'h00, idx});
    cyc(PH_DW, d);
  endtask
  task automatic rd(input logic [2:0] idx, input logic [7:0] e);
    cyc(PH_BAR, {5'h00, idx});
    cyc(PH_DTB, 8'h00);
    chk("rd_oe_n", 16'h0000, 16'(hd_oe_n));
    chk("rd_data", 16'(e), 16'(hd_o));
    cyc(PH_NACT, 8'h00);
    chk("rd_float", 16'h0001, 16'(hd_oe_n));
  endtask
  // acknowledge a request, fetch its vector, end its service
  task automatic ack(input logic [7:0] v);
    repeat (20) if (irq_oe_n !== 1'b0) @(posedge clk);
    chk("irq", 16'h0000, 16'(irq_oe_n));
    cyc(PH_IRQ_ACKNOWLEDGE, 8'h00);
    chk("irq_taken", 16'h0001, 16'(irq_oe_n));
    cyc(PH_IAB, 8'h00);
    chk("vec_oe_n", 16'h0000, 16'(hd_oe_n));
    chk("vec", 16'(v), 16'(hd_o));
    cyc(PH_NACT, 8'h00);
    eos <= 1'b1;
    repeat (5) @(posedge clk);
    eos <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic idle();
    repeat (300) if (go !== 1'b0) @(posedge clk);
    chk("go_idle", 16'h0000, 16'(go));
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    {stb, dir, cb, ca, eos, mask_in, nrst} = '0;
    {ce_n, power_clear_n_n, err_n} = '1;
    hd = 8'h00;
    pull = 16'h0000;
    lat = 8'h3c;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    ce_n <= 1'b0;
    repeat (6) @(posedge clk);
    rd(IDX_CTRL, 8'hc3);
    rd(IDX_DATA_HI, 8'hff);
    rd(IDX_TMR_LO, 8'hff);
    for (int i = 5; i < 8; i++) rd(3'(i), 8'h00);
    // vectors, then an unselected write that must be ignored
    for (int i = 5; i < 8; i++) wr(3'(i), 8'(i * 17));
    ce_n <= 1'b1;
    wr(IDX_VEC_PER, 8'hee);
    ce_n <= 1'b0;
    for (int i = 5; i < 8; i++) rd(3'(i), 8'(i * 17));
    // status bits stay read-only
    wr(IDX_CTRL, 8'hff);
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL, 8'hc3);
    // odd low byte, handshake with a slow peripheral
    wr(IDX_DATA_LO, 8'h5b);
    chk("go", 16'h0001, 16'(go));
    idle();
    pull <= 16'h0100;
    rd(IDX_CTRL, 8'h03);
    rd(IDX_DATA_HI, 8'hfe);
    pull <= 16'h0000;
    idle();
    // sixteen-bit width: only the high byte restarts the peripheral
    wr(IDX_CTRL, 8'h04);
    wr(IDX_DATA_LO, 8'hff);
    chk("go_lo", 16'h0000, 16'(go));
    wr(IDX_DATA_HI, 8'hff);
    chk("go_hi", 16'h0001, 16'(go));
    idle();
    // prompt peripheral; error and attention pending behind the mask
    lat <= 8'h04;
    mask_in <= 1'b1;
    err_n <= 1'b0;
    wr(IDX_DATA_HI, 8'hff);
    wr(IDX_CTRL, 8'h08);
    chk("irq_masked", 16'h0001, 16'(irq_oe_n));
    mask_in <= 1'b0; // top of the chain tied low
    ack(8'h77);
    ack(8'h55);
    rd(IDX_CTRL, 8'hc9);
    err_n <= 1'b1;
    chk("mask_out", 16'h0000, 16'(mask_out));
    // timer end of count held off until its enable is set
    wr(IDX_TMR_LO, 8'h02);
    wr(IDX_TMR_HI, 8'h00);
    rd(IDX_TMR_HI, 8'h00);
    wr(IDX_CTRL, 8'h20);
    repeat (30) cyc(PH_NACT, 8'h00);
    chk("irq_tie", 16'h0001, 16'(irq_oe_n));
    wr(IDX_CTRL, 8'h30);
    ack(8'h66);
    chk("mask_out", 16'h0000, 16'(mask_out));
    // power clear restores the initial state
    power_clear_n_n <= 1'b0;
    repeat (8) @(posedge clk);
    power_clear_n_n <= 1'b1;
    repeat (8) @(posedge clk);
    rd(IDX_CTRL, 8'hc3);
    rd(IDX_VEC_TMR, 8'h00);
    summarize();
  end
endmodule
`default_nettype wire

// ==== verification/pib_io_buffer_checker.sv ====
// port-level assertions for the peripheral i/o buffer
`default_nettype none
module pib_io_buffer_checker (
  input wire logic        REF_CLK_I,
  input wire logic        NRST_I,
  input wire logic        HOST_STROBE_CLOCK_I,
  input wire logic        HOST_DATA_LINES_OE_N_O,
  input wire logic        IRQ_OUT_N_O,
  input wire logic        IRQ_OUT_N_OE_N_O,
  input wire logic        PRIORITY_MASK_IN_I,
  input wire logic        PRIORITY_MASK_OUT_O,
  input wire logic        POWER_CLEAR_N_I,
  input wire logic [15:0] PERIPH_LINES_O,
  input wire logic [15:0] PERIPH_LINES_OE_N_O,
  input wire logic        PERIPH_GO_O,
  input wire logic        ATTENTION_REQ_N_I
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  // ****************
  // multi-step behaviours
  // ****************
  sequence att_fall;
    $fell(ATTENTION_REQ_N_I) ##1 !ATTENTION_REQ_N_I [*3];
  endsequence
  sequence mask_held;
    PRIORITY_MASK_IN_I [*8];
  endsequence
  sequence irq_held;
    !IRQ_OUT_N_OE_N_O ##1 !IRQ_OUT_N_OE_N_O;
  endsequence
  // ****************
  // assertions
  // ****************
  rst_vals_a: assert property (disable iff (1'b0)
    !NRST_I |=> HOST_DATA_LINES_OE_N_O && IRQ_OUT_N_OE_N_O && !PRIORITY_MASK_OUT_O
      && PERIPH_LINES_OE_N_O == 16'hffff && !PERIPH_GO_O) else $error("reset state wrong");
  drive_low_a: assert property (
    PERIPH_LINES_O == 16'h0000 && (IRQ_OUT_N_OE_N_O || !IRQ_OUT_N_O))
    else $error("driven level not low");
  read_drive_a: assert property (
    $fell(HOST_DATA_LINES_OE_N_O) |-> $past(HOST_STROBE_CLOCK_I, 3))
    else $error("host bus driven without strobe");
  read_hold_a: assert property (
    $fell(HOST_DATA_LINES_OE_N_O) |-> !HOST_DATA_LINES_OE_N_O [*6])
    else $error("host drive too short");
  mask_chain_a: assert property (mask_held |-> PRIORITY_MASK_OUT_O)
    else $error("mask not passed on");
  masked_quiet_a: assert property (mask_held |-> !$fell(IRQ_OUT_N_OE_N_O))
    else $error("request while upstream busy");
  mask_req_a: assert property (irq_held |-> PRIORITY_MASK_OUT_O)
    else $error("mask low while requesting");
  go_att_a: assert property (att_fall |-> ##[1:6] !PERIPH_GO_O)
    else $error("go not dropped after attention");
  lines_write_a: assert property (
    !$stable(PERIPH_LINES_OE_N_O) |-> $past(HOST_STROBE_CLOCK_I, 3)
      || !$past(POWER_CLEAR_N_I, 3)) else $error("lines changed without cause");
endmodule
bind pib_io_buffer pib_io_buffer_checker chk_i (.REF_CLK_I, .NRST_I, .HOST_STROBE_CLOCK_I,
  .HOST_DATA_LINES_OE_N_O, .IRQ_OUT_N_O, .IRQ_OUT_N_OE_N_O, .PRIORITY_MASK_IN_I,
  .PRIORITY_MASK_OUT_O, .POWER_CLEAR_N_I, .PERIPH_LINES_O, .PERIPH_LINES_OE_N_O,
  .PERIPH_GO_O, .ATTENTION_REQ_N_I);
`default_nettype wire

// ==== verification/pib_periph_model.sv ====
// peripheral model: weak-high data lines and attention handshake
`default_nettype none
module pib_periph_model (
  input  wire logic        clk_i,
  input  wire logic        go_i,
  input  wire logic [15:0] oe_n_i,
  input  wire logic [15:0] pull_i,
  input  wire logic [7:0]  lat_i,
  output logic      [15:0] lines_o,
  output var logic         att_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt   = 0;
  logic att_q = 1'b1;
  // released lines float high unless the peripheral sinks them
  assign lines_o = oe_n_i & ~pull_i;
  // attention idles high, falls lat_i cycles after go, rises once go drops
  assign att_n_o = att_q;
  always @(posedge clk_i) begin
    if (!go_i) begin
      cnt <= 0;
      att_q <= 1'b1;
    end else if (cnt >= int'(lat_i)) begin
      att_q <= 1'b0;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire
